// ==== design/dif_cfg.svh ====
// Constants for the digital input function logic
`ifndef DIF_CFG_SVH
`define DIF_CFG_SVH
// Register byte offsets
`define DIF_OFS_CTRL    8'h00
`define DIF_OFS_FSEL_LO 8'h04
`define DIF_OFS_FSEL_HI 8'h08
`define DIF_OFS_JOG     8'h0C
`define DIF_OFS_TRIM    8'h10
`define DIF_OFS_LOWER   8'h14
`define DIF_OFS_TON     8'h18
`define DIF_OFS_TOFF    8'h1C
`define DIF_OFS_FSTDEC  8'h20
`define DIF_OFS_SPDREF  8'h24
`define DIF_OFS_STATUS  8'h28
`define DIF_OFS_SPEED   8'h2C
// Control register fields
`define DIF_CTRL_SRC    0
`define DIF_CTRL_MEM    1
`define DIF_CTRL_REV_LO 2
`define DIF_CTRL_STP_LO 4
`define DIF_CTRL_PI     6
// Reset values
`define DIF_CTRL_RST    7'h01
`define DIF_FSEL_RST    32'h0F0F0F0F
// Input function codes
`define DIF_FN_RAMPHOLD 8'h0A
`define DIF_FN_UP       8'h10
`define DIF_FN_DOWN     8'h11
`define DIF_FN_FJOG     8'h12
`define DIF_FN_RJOG     8'h13
`define DIF_FN_FRESET   8'h14
`define DIF_FN_FS_NO    8'h15
`define DIF_FN_FS_NC    8'h17
`define DIF_FN_TIMER    8'h18
`define DIF_FN_PIDIS    8'h19
`define DIF_FN_LOCK     8'h1B
`define DIF_FN_TRIM_UP  8'h1C
`define DIF_FN_TRIM_DN  8'h1D
`define DIF_FN_SH       8'h1E
`define DIF_FN_EXT_HI   4'h2
// Timing
`define DIF_CLK_NS      100
`define DIF_MS_NS       1000000
`define DIF_JOG_MS      16'd500
`define DIF_SH_MS       16'd100
// Marks a valid retained up/down memory
`define DIF_NV_TAG      8'hA5
`endif

// ==== design/dif_pkg.sv ====
// Types for the digital input function logic
package dif_pkg;
   typedef enum logic [1:0] {STOP_DECEL, STOP_COAST, STOP_FAST,
                             STOP_NONE} dif_stop_t;
   typedef enum logic [1:0] {FSRC_NONE, FSRC_JOG, FSRC_EXT} dif_fsrc_t;
   typedef struct packed {
      logic        run;
      logic        rev;
      logic        fast_decel;
      dif_stop_t   stop_mode;
      logic [15:0] speed;
   } dif_cmd_t;
   typedef struct packed {
      logic        latched;
      logic        minor;
      logic        conflict;
      dif_fsrc_t   source;
      logic [2:0]  terminal;
      logic [7:0]  code;
   } dif_fault_t;
endpackage : dif_pkg

// ==== design/dif_top.sv ====
// Digital input function logic with AHB-Lite register slave
//
// Contract
// - No memory: fresh run ramps to lower limit
// - Memory on: fresh run resumes last up/down speed
// - Memory on: up/down without run resets store
// - Up/down inactive when keypad is speed source
// - Jog beats the up/down speed command
// - Jog inputs run at jog speed, own direction
// - Jog overrides all; reverse jog obeys inhibit; here a latched fault or fast stop still blocks jog
// - Both jogs 500 ms raise external fault
// - Fault closes contact, decelerates unless method chosen
// - Fault clears after run off, by reset
// - Fast stop decelerates with fast stop time
// - Fast stop blocks run until run recycled
// - Timer output follows on and off delays
// - PI disable input bypasses PI control
// - Lockout rejects writes except speed command
// - Lone trim code flags configuration conflict
// - Trim adds or subtracts step while held
// - Sample-hold held 100 ms captures analog
// - Sample-hold with ramp hold, up/down, trim conflicts
// - Power cycle clears sampled reference to zero
// - Codes 20 to 2F are external faults
// - Up/down run starts at the lower limit, or at the stored speed with memory on
// - Up and down equal leaves speed unchanged
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dif_cfg.svh"
module dif_top #(
   parameter int MS_CYC = `DIF_MS_NS / `DIF_CLK_NS
) (
   input  wire logic              sys_clk,
   input  wire logic              sys_rst,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   input  wire logic [7:0]        contact_in,
   input  wire logic              run_term_in,
   input  wire logic              kp_run_in,
   input  wire logic              kp_reset_in,
   input  wire logic [15:0]       analog_in,
   output dif_pkg::dif_cmd_t      drive_cmd,
   output dif_pkg::dif_fault_t    fault_stat,
   output logic                   fault_contact,
   output logic                   timer_out,
   output logic                   pi_active,
   output logic [15:0]            fast_stop_decel_time
);
   import dif_pkg::*;

   // Mask of inputs whose function select equals a code
   function automatic logic [7:0] has_code(input logic [63:0] sel,
                                           input logic [7:0]  code);
      logic [7:0] m;
      m = 8'h00;
      for (int i = 0; i < 8; i++) begin
         m[i] = (sel[i*8 +: 8] == code);
      end
      return m;
   endfunction : has_code

   // Registers
   logic [6:0]  ctrl_r;
   logic [63:0] fsel_r;
   logic [15:0] jog_r, trim_r, lower_r, ton_r, toff_r, fstdec_r, spdref_r;
   logic        wr_pend_r;
   logic [7:0]  wr_addr_r, rd_addr_r;
   logic [10:0] sy1_r, sy2_r;
   logic [15:0] ms_cnt_r;
   logic [15:0] jb_cnt_r, sh_cnt_r, ton_cnt_r, toff_cnt_r;
   logic        run_q_r, fs_blk_r, sh_done_r, sh_valid_r, timer_r;
   logic [15:0] mop_r, sh_ref_r, speed_r;
   logic [15:0] nv_mem_r;
   logic [7:0]  nv_tag_r;
   logic        run_r, rev_r;
   dif_fault_t  flt_r;
   dif_stop_t   fstop_r;

   // Synchronised contacts and keypad levels
   wire [7:0]  cin   = sy2_r[7:0];
   wire        run_t = sy2_r[8];
   wire        kp_rn = sy2_r[9];
   wire        kp_rs = sy2_r[10];
   wire        src_t = ctrl_r[`DIF_CTRL_SRC];
   wire        mem_en = ctrl_r[`DIF_CTRL_MEM];
   wire        rev_dis = ctrl_r[`DIF_CTRL_REV_LO];
   wire [1:0]  stp_sel = ctrl_r[`DIF_CTRL_STP_LO +: 2];
   wire        ms_tick = (ms_cnt_r == 16'(MS_CYC - 1));

   // Function decode per code
   wire [7:0] m_up   = has_code(fsel_r, `DIF_FN_UP);
   wire [7:0] m_dn   = has_code(fsel_r, `DIF_FN_DOWN);
   wire [7:0] m_fj   = has_code(fsel_r, `DIF_FN_FJOG);
   wire [7:0] m_rj   = has_code(fsel_r, `DIF_FN_RJOG);
   wire [7:0] m_rst  = has_code(fsel_r, `DIF_FN_FRESET);
   wire [7:0] m_fsno = has_code(fsel_r, `DIF_FN_FS_NO);
   wire [7:0] m_fsnc = has_code(fsel_r, `DIF_FN_FS_NC);
   wire [7:0] m_tmr  = has_code(fsel_r, `DIF_FN_TIMER);
   wire [7:0] m_pid  = has_code(fsel_r, `DIF_FN_PIDIS);
   wire [7:0] m_lock = has_code(fsel_r, `DIF_FN_LOCK);
   wire [7:0] m_tu   = has_code(fsel_r, `DIF_FN_TRIM_UP);
   wire [7:0] m_td   = has_code(fsel_r, `DIF_FN_TRIM_DN);
   wire [7:0] m_sh   = has_code(fsel_r, `DIF_FN_SH);
   wire [7:0] m_rh   = has_code(fsel_r, `DIF_FN_RAMPHOLD);

   // External fault terminals, one decoder per input
   logic [7:0] ext_maj, ext_min;
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_ext
         wire [7:0] c  = fsel_r[g*8 +: 8];
         wire       hit = (c[7:4] == `DIF_FN_EXT_HI) && (cin[g] ^ c[0])
                          && (!c[1] || run_r);
         assign ext_maj[g] = hit && (c[3:2] != 2'b11);
         assign ext_min[g] = hit && (c[3:2] == 2'b11);
      end
   endgenerate

   // Lowest-numbered major external fault
   logic [2:0] ext_term;
   always_comb begin
      ext_term = 3'd0;
      for (int i = 7; i >= 0; i--) begin
         if (ext_maj[i]) begin
            ext_term = 3'(i);
         end
      end
   end
   wire [7:0] ext_code = fsel_r[ext_term*8 +: 8];

   // Configuration conflicts
   wire has_up = |m_up;
   wire has_dn = |m_dn;
   wire has_tu = |m_tu;
   wire has_td = |m_td;
   wire has_sh = |m_sh;
   wire conflict = (has_up ^ has_dn) || (has_tu ^ has_td)
                   || ((has_up || has_dn) && (|m_rh))
                   || (has_sh && ((|m_rh) || has_up || has_dn
                                  || has_tu || has_td));

   // Input levels per function
   wire up_c   = |(m_up & cin);
   wire dn_c   = |(m_dn & cin);
   wire fj_c   = |(m_fj & cin);
   wire rj_c   = |(m_rj & cin);
   wire fs_act = (|(m_fsno & cin)) || (|(m_fsnc & ~cin));
   wire tmr_c  = |(m_tmr & cin);
   wire lock_c = |(m_lock & cin);
   wire tu_c   = |(m_tu & cin);
   wire td_c   = |(m_td & cin);
   wire sh_c   = |(m_sh & cin);
   wire rst_c  = |(m_rst & cin);

   // Run request and jog
   wire run_req = run_t || kp_rn;
   wire rj_ok   = rj_c && !rev_dis;
   wire jog_act = fj_c || rj_ok;
   wire mop_on  = has_up && has_dn && src_t && !conflict;
   wire run_ok  = !flt_r.latched && !fs_blk_r && !fs_act;
   wire run_nxt = run_ok && (run_req || jog_act);
   wire fresh   = run_req && !run_q_r;
   wire nv_ok   = (nv_tag_r == `DIF_NV_TAG);
   wire jb_flt  = (jb_cnt_r > `DIF_JOG_MS);

   // Base speed selection
   logic [15:0] base_spd;
   always_comb begin
      if (jog_act) begin
         base_spd = jog_r;
      end else if (has_sh && !conflict) begin
         base_spd = sh_ref_r;
      end else if (mop_on) begin
         base_spd = mop_r;
      end else if (src_t) begin
         base_spd = analog_in;
      end else begin
         base_spd = spdref_r;
      end
   end

   wire trim_on = has_tu && has_td && src_t && !conflict && !jog_act;
   wire [16:0] up_sum = {1'b0, base_spd} + {1'b0, trim_r};
   wire [15:0] spd_nxt =
      (trim_on && tu_c && !td_c) ? (up_sum[16] ? 16'hFFFF : up_sum[15:0]) :
      (trim_on && td_c && !tu_c) ?
         ((base_spd > trim_r) ? base_spd - trim_r : 16'h0000) : base_spd;

   // Input synchronisers
   // two flop sync
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sy1_r <= 11'h000;
         sy2_r <= 11'h000;
      end else begin
         sy1_r <= {kp_reset_in, kp_run_in, run_term_in, contact_in};
         sy2_r <= sy1_r;
      end
   end

   // Millisecond tick and hold counters
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ms_cnt_r   <= 16'h0000;
         jb_cnt_r   <= 16'h0000;
         sh_cnt_r   <= 16'h0000;
         ton_cnt_r  <= 16'h0000;
         toff_cnt_r <= 16'h0000;
      end else begin
         ms_cnt_r <= ms_tick ? 16'h0000 : ms_cnt_r + 16'h0001;
         jb_cnt_r <= !(fj_c && rj_c) ? 16'h0000 :
                     (ms_tick && !jb_flt) ? jb_cnt_r + 16'h0001 : jb_cnt_r;
         sh_cnt_r <= !sh_c ? 16'h0000 :
                     (ms_tick && sh_cnt_r != 16'hFFFF) ?
                        sh_cnt_r + 16'h0001 : sh_cnt_r;
         ton_cnt_r <= !tmr_c ? 16'h0000 :
                      (ms_tick && ton_cnt_r != 16'hFFFF) ?
                         ton_cnt_r + 16'h0001 : ton_cnt_r;
         toff_cnt_r <= tmr_c ? 16'h0000 :
                       (ms_tick && toff_cnt_r != 16'hFFFF) ?
                          toff_cnt_r + 16'h0001 : toff_cnt_r;
      end
   end

   // Timer output, fast stop block and sample-hold
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         timer_r    <= 1'b0;
         fs_blk_r   <= 1'b0;
         sh_done_r  <= 1'b0;
         sh_valid_r <= 1'b0;
         sh_ref_r   <= 16'h0000;
         run_q_r    <= 1'b0;
      end else begin
         run_q_r <= run_req;
         if (tmr_c && ton_cnt_r >= ton_r) begin
            timer_r <= 1'b1;
         end else if (!tmr_c && toff_cnt_r >= toff_r) begin
            timer_r <= 1'b0;
         end
         if (fs_act) begin
            fs_blk_r <= 1'b1;
         end else if (!run_req) begin
            fs_blk_r <= 1'b0;
         end
         sh_done_r <= sh_c && (sh_done_r || sh_cnt_r > `DIF_SH_MS);
         if (sh_c && !sh_done_r && sh_cnt_r > `DIF_SH_MS) begin
            sh_ref_r   <= analog_in;
            sh_valid_r <= 1'b1;
         end
      end
   end

   // Up/down speed and its retained memory
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mop_r <= 16'h0000;
      end else if (mop_on && fresh) begin
         mop_r <= (mem_en && nv_ok && nv_mem_r > lower_r) ?
                  nv_mem_r : lower_r;
      end else if (mop_on && run_r && ms_tick) begin
         if (up_c && !dn_c && mop_r != 16'hFFFF) begin
            mop_r <= mop_r + 16'h0001;
         end else if (dn_c && !up_c && mop_r > lower_r) begin
            mop_r <= mop_r - 16'h0001;
         end
      end
   end

   // Retained store survives reset to emulate power loss memory
   always_ff @(posedge sys_clk) begin
      if (mop_on && mem_en && !run_req && (up_c || dn_c)) begin
         nv_mem_r <= lower_r;
         nv_tag_r <= `DIF_NV_TAG;
      end else if (mop_on && run_r && run_req) begin
         nv_mem_r <= mop_r;
         nv_tag_r <= `DIF_NV_TAG;
      end
   end

   // Fault latch and drive command
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         flt_r   <= '0;
         fstop_r <= STOP_COAST;
         run_r   <= 1'b0;
         rev_r   <= 1'b0;
         speed_r <= 16'h0000;
      end else begin
         run_r   <= run_nxt;
         rev_r   <= rj_ok && !fj_c;
         speed_r <= spd_nxt;
         flt_r.conflict <= conflict;
         flt_r.minor    <= |ext_min;
         if (jb_flt) begin
            flt_r.latched <= 1'b1;
            flt_r.source  <= FSRC_JOG;
            fstop_r       <= dif_stop_t'(stp_sel);
         end else if (|ext_maj) begin
            flt_r.latched  <= 1'b1;
            flt_r.source   <= FSRC_EXT;
            flt_r.terminal <= ext_term;
            flt_r.code     <= ext_code;
            fstop_r        <= dif_stop_t'(ext_code[3:2]);
         end else if (flt_r.latched && !run_req && (kp_rs || rst_c)) begin
            flt_r.latched <= 1'b0;
            flt_r.source  <= FSRC_NONE;
         end
      end
   end

   // Drive command outputs
   // fault stop method
   assign drive_cmd.stop_mode  = flt_r.latched ? fstop_r :
                                 (fs_blk_r ? STOP_FAST :
                                  dif_stop_t'(stp_sel));
   assign drive_cmd.run        = run_r;
   assign drive_cmd.rev        = rev_r;
   assign drive_cmd.fast_decel = fs_blk_r && !flt_r.latched;
   assign drive_cmd.speed      = speed_r;
   assign fault_stat           = flt_r;
   assign fault_contact        = flt_r.latched;
   assign timer_out            = timer_r;
   assign pi_active            = ctrl_r[`DIF_CTRL_PI] && !(|(m_pid & cin));
   assign fast_stop_decel_time = fstdec_r;

   // AHB-Lite slave: zero wait states, always OKAY
   wire acc = hsel && hready && htrans[1];
   wire wr_ok = wr_pend_r && (!lock_c || wr_addr_r == `DIF_OFS_SPDREF);
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         rd_addr_r <= 8'hFF;
      end else begin
         wr_pend_r <= acc && hwrite && (haddr[31:8] == 24'h000000);
         wr_addr_r <= haddr[7:0];
         rd_addr_r <= (acc && !hwrite && haddr[31:8] == 24'h000000) ?
                      haddr[7:0] : 8'hFF;
      end
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl_r   <= `DIF_CTRL_RST;
         fsel_r   <= {`DIF_FSEL_RST, `DIF_FSEL_RST};
         jog_r    <= 16'h0000;
         trim_r   <= 16'h0000;
         lower_r  <= 16'h0000;
         ton_r    <= 16'h0000;
         toff_r   <= 16'h0000;
         fstdec_r <= 16'h0000;
         spdref_r <= 16'h0000;
      end else if (wr_ok) begin
         unique case (wr_addr_r)
            `DIF_OFS_CTRL:    ctrl_r          <= hwdata[6:0];
            `DIF_OFS_FSEL_LO: fsel_r[31:0]    <= hwdata;
            `DIF_OFS_FSEL_HI: fsel_r[63:32]   <= hwdata;
            `DIF_OFS_JOG:     jog_r           <= hwdata[15:0];
            `DIF_OFS_TRIM:    trim_r          <= hwdata[15:0];
            `DIF_OFS_LOWER:   lower_r         <= hwdata[15:0];
            `DIF_OFS_TON:     ton_r           <= hwdata[15:0];
            `DIF_OFS_TOFF:    toff_r          <= hwdata[15:0];
            `DIF_OFS_FSTDEC:  fstdec_r        <= hwdata[15:0];
            `DIF_OFS_SPDREF:  spdref_r        <= hwdata[15:0];
            default: ;
         endcase
      end
   end

   // Read mux on the latched address phase
   wire [31:0] status = {9'h000, flt_r.source, flt_r.code,
                         flt_r.terminal, pi_active, lock_c, fs_blk_r,
                         rev_r, run_r, timer_r, sh_valid_r, conflict,
                         flt_r.minor, flt_r.latched};
   always_comb begin
      unique case (rd_addr_r)
         `DIF_OFS_CTRL:    hrdata = {25'h0000000, ctrl_r};
         `DIF_OFS_FSEL_LO: hrdata = fsel_r[31:0];
         `DIF_OFS_FSEL_HI: hrdata = fsel_r[63:32];
         `DIF_OFS_JOG:     hrdata = {16'h0000, jog_r};
         `DIF_OFS_TRIM:    hrdata = {16'h0000, trim_r};
         `DIF_OFS_LOWER:   hrdata = {16'h0000, lower_r};
         `DIF_OFS_TON:     hrdata = {16'h0000, ton_r};
         `DIF_OFS_TOFF:    hrdata = {16'h0000, toff_r};
         `DIF_OFS_FSTDEC:  hrdata = {16'h0000, fstdec_r};
         `DIF_OFS_SPDREF:  hrdata = {16'h0000, spdref_r};
         `DIF_OFS_STATUS:  hrdata = status;
         `DIF_OFS_SPEED:   hrdata = {16'h0000, speed_r};
         default:          hrdata = 32'h00000000;
      endcase
   end
endmodule : dif_top
`default_nettype wire

// ==== dv/dif_top_props.sv ====
// Port checker for the digital input function block
`timescale 1ns/1ps
`default_nettype none
module dif_top_chk #(
   parameter int MS_CYC = 10
) (
   input wire logic                sys_clk,
   input wire logic                sys_rst,
   input wire logic                hreadyout,
   input wire logic                hresp,
   input wire logic [7:0]          contact_in,
   input wire logic                run_term_in,
   input wire logic                kp_run_in,
   input wire logic                kp_reset_in,
   input wire dif_pkg::dif_cmd_t   drive_cmd,
   input wire dif_pkg::dif_fault_t fault_stat,
   input wire logic                fault_contact
);
   import dif_pkg::*;
   int unsigned pair_r;
   int unsigned act_r;
   int unsigned run_r;
   logic        act_w;
   // Any field input that may start or clear something
   assign act_w = (|contact_in) || kp_reset_in || run_term_in || kp_run_in;
   // Cycles with two contacts closed, and cycles since last activity
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pair_r <= 0;
         act_r  <= 99;
         run_r  <= 99;
      end else begin
         pair_r <= ($countones(contact_in) > 1) ? pair_r + 1 : 0;
         act_r  <= act_w ? 0 : (act_r < 99) ? act_r + 1 : act_r;
         run_r  <= (run_term_in || kp_run_in) ? 0 :
                   (run_r < 99) ? run_r + 1 : run_r;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   chk_bus_okay: assert property (hreadyout && !hresp)
      else $error("slave not ready or not OKAY");
   chk_fault_pin: assert property (
      fault_contact == fault_stat.latched) else $error("fault contact wrong");
   chk_fault_stop: assert property (
      $rose(fault_stat.latched) |-> ##[0:2] !drive_cmd.run)
      else $error("output kept running on fault");
   chk_clear_cause: assert property (
      $fell(fault_stat.latched) |-> act_r < 8 && run_r > 1)
      else $error("fault cleared without reset or with run on");
   chk_jog_hold: assert property (
      $rose(fault_stat.latched) && fault_stat.source == FSRC_JOG
      |-> pair_r >= 500 * MS_CYC) else $error("jog fault too early");
   chk_ext_code: assert property (
      fault_stat.latched && fault_stat.source == FSRC_EXT
      |-> fault_stat.code[7:4] == 4'h2) else $error("bad external code");
   chk_sync_delay: assert property (
      $changed(contact_in) |=> $stable(fault_contact))
      else $error("contact acted before synchronising");
   chk_run_cause: assert property (
      $rose(drive_cmd.run) |-> act_r < 8) else $error("run without input");
   cov_jog_fault: cover property ($rose(fault_stat.latched)
      && fault_stat.source == FSRC_JOG);
   cov_ext_fault: cover property ($rose(fault_stat.latched)
      && fault_stat.source == FSRC_EXT);
   cov_clear: cover property ($fell(fault_stat.latched));
endmodule : dif_top_chk
bind dif_top dif_top_chk #(.MS_CYC(MS_CYC)) u_chk (.sys_clk, .sys_rst,
   .hreadyout, .hresp, .contact_in, .run_term_in, .kp_run_in, .kp_reset_in,
   .drive_cmd, .fault_stat, .fault_contact);
`default_nettype wire

// ==== dv/dif_field_model.sv ====
// Contact and keypad model that drives the field-side inputs
`timescale 1ns/1ps
`default_nettype none
module dif_field_model (
   input  wire logic        sys_clk,
   input  wire logic [7:0]  sw_req,
   input  wire logic        run_req,
   input  wire logic        kp_run_req,
   input  wire logic        kp_rst_req,
   input  wire logic [15:0] ana_req,
   output var logic [7:0]   contact_in,
   output var logic         run_term_in,
   output var logic         kp_run_in,
   output var logic         kp_reset_in,
   output var logic [15:0]  analog_in
);
   // Everything open and at zero before the first edge
   initial begin
      contact_in  = 8'h00;
      run_term_in = 1'b0;
      kp_run_in   = 1'b0;
      kp_reset_in = 1'b0;
      analog_in   = 16'h0000;
   end
   // Contacts and keypad move just after an edge, unrelated to the bus
   always @(posedge sys_clk) begin
      contact_in  <= sw_req;
      run_term_in <= run_req;
      kp_run_in   <= kp_run_req;
      kp_reset_in <= kp_rst_req;
      analog_in   <= ana_req;
   end
endmodule : dif_field_model
`default_nettype wire

// ==== dv/digital_input_function_logic_bench.sv ====
// Self-checking bench for the digital input function logic
`timescale 1ns/1ps
`default_nettype none
`include "dif_cfg.svh"
module digital_input_function_logic_bench;
   import dif_pkg::*;
   localparam int MS = 10;
   logic        sys_clk, sys_rst, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdat;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  contact_in, sw;
   logic        run_term_in, kp_run_in, kp_reset_in, run_sw, kp_rst_sw;
   logic [15:0] analog_in, ana, fs_time;
   logic        fault_contact, timer_out, pi_active;
   dif_cmd_t    drive_cmd;
   dif_fault_t  fault_stat;
   int          bad_count, total_checks;
   dif_top #(.MS_CYC(MS)) u_dut (.sys_clk, .sys_rst, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .contact_in, .run_term_in, .kp_run_in,
      .kp_reset_in, .analog_in, .drive_cmd, .fault_stat, .fault_contact,
      .timer_out, .pi_active, .fast_stop_decel_time(fs_time));
   dif_field_model u_field (.sys_clk, .sw_req(sw), .run_req(run_sw),
      .kp_run_req(1'b0), .kp_rst_req(kp_rst_sw), .ana_req(ana),
      .contact_in, .run_term_in, .kp_run_in, .kp_reset_in, .analog_in);
   // Clock source
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic cmp(input string n, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task automatic cmpb(input string n, input logic e, g);
      cmp(n, {31'h0, e}, {31'h0, g});
   endtask : cmpb
   // One AHB-Lite single transfer; read data taken as data phase ends
   task automatic bus(input logic [31:0] a, d, input logic w);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      rdat = hrdata;
   endtask : bus
   task automatic wr(input logic [7:0] o, input logic [31:0] d);
      bus({24'h0, o}, d, 1'b1);
   endtask : wr
   task automatic rdc(input string n, input logic [7:0] o,
                      input logic [31:0] e);
      bus({24'h0, o}, 32'h0, 1'b0);
      cmp(n, e, rdat);
   endtask : rdc
   task automatic ms(input int n);
      repeat (n * MS) @(posedge sys_clk);
   endtask : ms
   task automatic settle;
      repeat (8) @(posedge sys_clk);
   endtask : settle
   // Watchdog well beyond the expected run of about 7000 cycles
   initial begin
      repeat (30000) @(posedge sys_clk);
      bad_count++;
      give_verdict;
   end
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'b010;
      hwdata = 32'h0;
      sw = 8'h00;
      run_sw = 1'b0;
      kp_rst_sw = 1'b0;
      ana = 16'h0000;
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      rdc("ctrl", `DIF_OFS_CTRL, 32'h1);
      rdc("fsel_hi", `DIF_OFS_FSEL_HI, 32'h0F0F0F0F);
      bus(32'h100, 32'h0, 1'b0);
      cmp("unmapped", 32'h0, rdat);
      // In0 fwd jog, in1 rev jog, in2 reset, in3 fast stop, in4 timer,
      // in5 lockout, in7 external fault
      wr(`DIF_OFS_FSEL_LO, 32'h15141312);
      wr(`DIF_OFS_FSEL_HI, 32'h200F1B18);
      wr(`DIF_OFS_JOG, 32'h123);
      wr(`DIF_OFS_TON, 32'h3);
      wr(`DIF_OFS_TOFF, 32'h2);
      wr(`DIF_OFS_FSTDEC, 32'h42);
      sw <= 8'h01;
      settle;
      cmpb("fjog run", 1'b1, drive_cmd.run);
      cmpb("fjog rev", 1'b0, drive_cmd.rev);
      cmp("fjog spd", 32'h123, {16'h0, drive_cmd.speed});
      sw <= 8'h00;
      wr(`DIF_OFS_CTRL, 32'h05);
      sw <= 8'h02;
      settle;
      cmpb("rjog inhibit", 1'b0, drive_cmd.run);
      wr(`DIF_OFS_CTRL, 32'h01);
      settle;
      cmpb("rjog rev", 1'b1, drive_cmd.rev);
      sw <= 8'h03;
      ms(495);
      cmpb("jog both early", 1'b0, fault_stat.latched);
      ms(10);
      cmpb("jog both fault", 1'b1, fault_stat.latched);
      cmpb("fault pin", 1'b1, fault_contact);
      cmpb("fault run", 1'b0, drive_cmd.run);
      sw <= 8'h00;
      settle;
      cmpb("no reset yet", 1'b1, fault_stat.latched);
      kp_rst_sw <= 1'b1;
      settle;
      kp_rst_sw <= 1'b0;
      cmpb("kp reset", 1'b0, fault_stat.latched);
      run_sw <= 1'b1;
      sw <= 8'h80;
      settle;
      cmpb("ext fault", 1'b1, fault_stat.latched);
      cmp("ext term", 32'h7, {29'h0, fault_stat.terminal});
      cmp("ext code", 32'h20, {24'h0, fault_stat.code});
      sw <= 8'h04;
      settle;
      cmpb("reset in run", 1'b1, fault_stat.latched);
      run_sw <= 1'b0;
      settle;
      cmpb("reset input", 1'b0, fault_stat.latched);
      sw <= 8'h00;
      run_sw <= 1'b1;
      settle;
      sw <= 8'h08;
      settle;
      cmpb("fast decel", 1'b1, drive_cmd.fast_decel);
      cmp("fast mode", 32'h2, {30'h0, drive_cmd.stop_mode});
      cmp("fast time", 32'h42, {16'h0, fs_time});
      sw <= 8'h00;
      settle;
      cmpb("fast block", 1'b0, drive_cmd.run);
      run_sw <= 1'b0;
      settle;
      run_sw <= 1'b1;
      settle;
      cmpb("fast restart", 1'b1, drive_cmd.run);
      run_sw <= 1'b0;
      sw <= 8'h10;
      ms(2);
      cmpb("timer on early", 1'b0, timer_out);
      ms(3);
      cmpb("timer on", 1'b1, timer_out);
      sw <= 8'h00;
      ms(1);
      cmpb("timer off early", 1'b1, timer_out);
      ms(3);
      cmpb("timer off", 1'b0, timer_out);
      sw <= 8'h20;
      settle;
      wr(`DIF_OFS_JOG, 32'h555);
      rdc("locked jog", `DIF_OFS_JOG, 32'h123);
      wr(`DIF_OFS_SPDREF, 32'h77);
      rdc("locked ref", `DIF_OFS_SPDREF, 32'h77);
      sw <= 8'h00;
      settle;
      wr(`DIF_OFS_FSEL_HI, 32'h201C1B18);
      settle;
      cmpb("lone trim", 1'b1, fault_stat.conflict);
      wr(`DIF_OFS_FSEL_HI, 32'h201E1B0A);
      settle;
      cmpb("hold ramp", 1'b1, fault_stat.conflict);
      wr(`DIF_OFS_FSEL_HI, 32'h201E1B18);
      settle;
      cmpb("hold alone", 1'b0, fault_stat.conflict);
      ana <= 16'h0456;
      run_sw <= 1'b1;
      sw <= 8'h40;
      ms(50);
      sw <= 8'h00;
      ana <= 16'h0789;
      settle;
      cmp("short hold", 32'h0, {16'h0, drive_cmd.speed});
      ana <= 16'h0456;
      sw <= 8'h40;
      ms(103);
      sw <= 8'h00;
      ana <= 16'h0789;
      settle;
      cmp("sampled", 32'h456, {16'h0, drive_cmd.speed});
      run_sw <= 1'b0;
      wr(`DIF_OFS_CTRL, 32'h41);
      wr(`DIF_OFS_FSEL_HI, 32'h20191B18);
      settle;
      cmpb("pi on", 1'b1, pi_active);
      sw <= 8'h40;
      settle;
      cmpb("pi bypass", 1'b0, pi_active);
      give_verdict;
   end
endmodule : digital_input_function_logic_bench
`default_nettype wire
